/* design/msb_bridge_regs.sv */
// scan bridge test data and instruction registers with local port chaining
`timescale 1ns/1ps
module msb_bridge_regs import msb_pkg::*; #(
	parameter int NUM_PORTS = DEF_PORTS
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic tck_b,
	input wire logic tdi_b,
	output logic tdo_b,
	output logic tdo_b_oe,
	input wire logic [SLOT_WIDTH-1:0] slot,
	input wire logic oe_n,
	input wire msb_tap_s tap,
	input wire logic addr_wait,
	input wire msb_dr_sel_s dr_sel,
	input wire msb_cnt_s cnt,
	input wire logic [NUM_PORTS-1:0] port_parked,
	input wire logic [NUM_PORTS-1:0] parked_in_reset_state,
	output logic [NUM_PORTS-1:0] local_port_tck,
	output logic [NUM_PORTS-1:0] local_port_tdi,
	input wire logic [NUM_PORTS-1:0] local_port_tdo,
	output logic selected,
	output logic [IR_WIDTH-1:0] instruction,
	output logic [MODE_WIDTH-1:0] chain_config,
	output logic [GROUP_WIDTH-1:0] group_select
);
	localparam int SYNC_W = 1 + 1 + SLOT_WIDTH + 1 + NUM_PORTS;

	// refuse port counts the mode register cannot address
	generate
		if (NUM_PORTS < 1 || NUM_PORTS > MAX_PORTS) begin : g_bad_ports
			$error("NUM_PORTS must lie between 1 and 5");
		end
	endgenerate

	// mode register bit that selects a given local port
	function automatic int port_mode_bit(input int port);
		port_mode_bit = (port < LOW_PORTS) ? (MODE_PORT_LOW + port) :
			(MODE_PORT_HIGH + port - LOW_PORTS);
	endfunction : port_mode_bit

	// address decode, used by the selection logic below
	function automatic logic addr_hit(input logic [IR_WIDTH-1:0] ir,
			input logic [SLOT_WIDTH-1:0] slots, input logic [GROUP_WIDTH-1:0] grp);
		logic [ADDR_WIDTH-1:0] a;
		a = ir[ADDR_WIDTH-1:0];
		addr_hit = 1'b0;
		if (ir[IR_WIDTH-1:ADDR_WIDTH] == ADDR_HIGH_ZERO) begin
			if (a <= ADDR_INDIV_MAX && a == slots[ADDR_WIDTH-1:0]) begin
				addr_hit = 1'b1;
			end else if (a == ADDR_BROADCAST) begin
				addr_hit = 1'b1;
			end else if (a[5:2] == ADDR_GROUP_PREFIX && a[1:0] == grp) begin
				addr_hit = 1'b1;
			end
		end
	endfunction : addr_hit

	logic [SYNC_W-1:0] sync_q;
	logic s_tck;
	logic s_tdi;
	logic s_oe_n;
	logic [SLOT_WIDTH-1:0] s_slot;
	logic [NUM_PORTS-1:0] s_ltdo;
	logic tck_d;
	logic tck_rise;
	logic tck_fall;
	logic [IR_WIDTH-1:0] instruction_shift_register;
	logic [BSR_WIDTH-1:0] pin_sample_register;
	logic bypass_stage;
	logic [GROUP_WIDTH-1:0] group_shift;
	logic [GROUP_WIDTH-1:0] group_select_register;
	logic [MODE_WIDTH-1:0] mode_shift;
	logic [MODE_WIDTH-2:0] mode_bits;
	logic cnt_status;
	logic [MODE_WIDTH-1:0] port_chain_config;
	msb_sel_e sel_state;
	msb_sel_e next_sel_state;
	logic reg_out;
	logic dr_shift;
	logic [NUM_PORTS:0] chain;
	logic [NUM_PORTS-1:0] port_active;
	logic [NUM_PORTS-1:0] pad;
	logic [NUM_PORTS-1:0] clk_en;
	logic [PARK_CNT_WIDTH-1:0] park_cnt [NUM_PORTS];

	// every pin, the link clock among them, passes two flops first
	msb_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.clk(clk),
		.resetn(resetn),
		.d({tck_b, tdi_b, slot, oe_n, local_port_tdo}),
		.q(sync_q)
	);

	assign {s_tck, s_tdi, s_slot, s_oe_n, s_ltdo} = sync_q;

	// edges of the backplane clock as seen by clk
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tck_d <= 1'b0;
		end else begin
			tck_d <= s_tck;
		end
	end

	assign tck_rise = s_tck & ~tck_d;
	assign tck_fall = ~s_tck & tck_d;
	assign selected = (sel_state == SEL_ON);
	assign dr_shift = tap.shift_dr & selected;

	// instruction register: capture, then shift towards bit 0
	always_ff @(posedge clk) begin
		if (!resetn) begin
			instruction_shift_register <= '0;
		end else if (tck_rise && tap.capture_ir) begin
			instruction_shift_register <= {s_slot[ADDR_WIDTH-1:0], IR_CAPTURE_LOW};
		end else if (tck_rise && tap.shift_ir) begin
			instruction_shift_register <= {s_tdi, instruction_shift_register[IR_WIDTH-1:1]};
		end
	end

	assign instruction = instruction_shift_register;

	// selection: set at an update rise; address wait deselects only at a tck rise, so it can lag
	always_comb begin
		next_sel_state = sel_state;
		case (sel_state)
			SEL_WAIT: begin
				if (tck_rise && tap.update_ir && addr_wait &&
						addr_hit(instruction_shift_register, s_slot, group_select_register)) begin
					next_sel_state = SEL_ON;
				end
			end
			SEL_ON: begin
				if (tap.tlr || (tck_rise && addr_wait)) begin
					next_sel_state = SEL_WAIT;
				end
			end
			default: begin
				next_sel_state = SEL_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sel_state <= SEL_WAIT;
		end else begin
			sel_state <= next_sel_state;
		end
	end

	// sample-only boundary cells; on-chip logic never sees their contents
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_sample_register <= '0;
		end else if (tck_rise && selected && dr_sel.boundary && tap.capture_dr) begin
			pin_sample_register <= {s_oe_n, s_slot};
		end else if (tck_rise && dr_shift && dr_sel.boundary) begin
			pin_sample_register <= {s_tdi, pin_sample_register[BSR_WIDTH-1:1]};
		end
	end

	// single bypass stage captures zero as usual
	always_ff @(posedge clk) begin
		if (!resetn) begin
			bypass_stage <= 1'b0;
		end else if (tck_rise && selected && dr_sel.bypass && tap.capture_dr) begin
			bypass_stage <= 1'b0;
		end else if (tck_rise && dr_shift && dr_sel.bypass) begin
			bypass_stage <= s_tdi;
		end
	end

	// group register: shift stage plus held value, cleared in reset state
	always_ff @(posedge clk) begin
		if (!resetn || tap.tlr) begin
			group_shift <= GROUP_RESET;
			group_select_register <= GROUP_RESET;
		end else if (tck_rise && selected && dr_sel.group) begin
			if (tap.capture_dr) begin
				group_shift <= group_select_register;
			end else if (tap.shift_dr) begin
				group_shift <= {s_tdi, group_shift[GROUP_WIDTH-1]};
			end else if (tap.update_dr) begin
				group_select_register <= group_shift;
			end
		end
	end

	assign group_select = group_select_register;

	// mode register: writable bits 6..0; bit 7 is counter status only
	always_ff @(posedge clk) begin
		if (!resetn || tap.tlr) begin
			mode_shift <= {1'b0, MODE_RESET};
			mode_bits <= MODE_RESET;
		end else if (tck_rise && selected && dr_sel.mode) begin
			if (tap.capture_dr) begin
				mode_shift <= port_chain_config;
			end else if (tap.shift_dr) begin
				mode_shift <= {s_tdi, mode_shift[MODE_WIDTH-1:1]};
			end else if (tap.update_dr) begin
				mode_bits <= mode_shift[MODE_WIDTH-2:0];
			end
		end
	end

	// status flag: a zero reached in the same cycle as a load still sets it
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cnt_status <= 1'b0;
		end else if (cnt.enabled && cnt.at_zero) begin
			cnt_status <= 1'b1;
		end else if (cnt.loaded) begin
			cnt_status <= 1'b0;
		end
	end

	assign port_chain_config = {cnt_status, mode_bits};
	assign chain_config = port_chain_config;

	// serial output of whichever register sits in the path
	always_comb begin
		if (tap.shift_ir) begin
			reg_out = instruction_shift_register[0];
		end else if (dr_sel.boundary) begin
			reg_out = pin_sample_register[0];
		end else if (dr_sel.group) begin
			reg_out = group_shift[0];
		end else if (dr_sel.mode) begin
			reg_out = mode_shift[0];
		end else begin
			reg_out = bypass_stage;
		end
	end

	assign chain[0] = reg_out;

	// local port chain: ascending order, each port retimed by its own pad
	generate
		for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
			assign port_active[i] = mode_bits[port_mode_bit(i)]
				& ~port_parked[i]
				& ~mode_bits[MODE_LOOPBACK];
			assign chain[i+1] = port_active[i] ? pad[i] : chain[i];

			// pad flop samples the returned data on the tck rise
			always_ff @(posedge clk) begin
				if (!resetn) begin
					pad[i] <= 1'b0;
				end else if (tck_rise) begin
					pad[i] <= s_ltdo[i];
				end
			end

			// local data launched on the falling edge, like the backplane output
			always_ff @(posedge clk) begin
				if (!resetn) begin
					local_port_tdi[i] <= 1'b0;
				end else if (tck_fall) begin
					local_port_tdi[i] <= chain[i];
				end
			end

			// pulses counted while parked in reset, saturating at the limit
			always_ff @(posedge clk) begin
				if (!resetn || !parked_in_reset_state[i]) begin
					park_cnt[i] <= '0;
				end else if (tck_rise && park_cnt[i] != PARK_CNT_LIMIT) begin
					park_cnt[i] <= park_cnt[i] + 10'h001;
				end
			end

			// clock gating; a stopped clock is held low
			always_comb begin
				if (!port_parked[i]) begin
					clk_en[i] = 1'b1;
				end else if (parked_in_reset_state[i]) begin
					clk_en[i] = (park_cnt[i] != PARK_CNT_LIMIT);
				end else if (cnt.enabled && cnt.at_zero) begin
					clk_en[i] = 1'b0;
				end else begin
					clk_en[i] = ~mode_bits[MODE_CLK_STOP];
				end
			end

			// local clock is the sampled backplane clock, gated, from a flop
			always_ff @(posedge clk) begin
				if (!resetn) begin
					local_port_tck[i] <= 1'b0;
				end else begin
					local_port_tck[i] <= s_tck & clk_en[i];
				end
			end
		end
	endgenerate

	// backplane output changes on the falling edge and only drives when selected
	always_ff @(posedge clk) begin
		if (!resetn) begin
			tdo_b <= 1'b0;
			tdo_b_oe <= 1'b0;
		end else if (tck_fall) begin
			tdo_b <= chain[NUM_PORTS];
			tdo_b_oe <= selected & (tap.shift_ir | tap.shift_dr);
		end
	end

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	ir_shift_in_a: assert property (
		tck_rise && tap.shift_ir && !tap.capture_ir |=> instruction_shift_register[7] == $past(s_tdi)
	) else $error("instruction register did not shift in tdi");

	ir_capture_a: assert property (
		tck_rise && tap.capture_ir |=>
			instruction_shift_register == {$past(s_slot[5:0]), 2'b01}
	) else $error("instruction capture pattern wrong");

	bcast_select_a: assert property (
		tck_rise && tap.update_ir && addr_wait && instruction_shift_register == 8'h3b
			&& sel_state == SEL_WAIT |=> selected
	) else $error("broadcast address did not select");

	group_clear_a: assert property (
		tap.tlr |=> group_select_register == 2'h0
	) else $error("group register not cleared in reset state");

	bsr_capture_a: assert property (
		tck_rise && selected && dr_sel.boundary && tap.capture_dr |=>
			pin_sample_register == {$past(s_oe_n), $past(s_slot)}
	) else $error("boundary capture order wrong");

	loopback_excl_a: assert property (
		mode_bits[MODE_LOOPBACK] |-> port_active == '0
	) else $error("loopback left a port in the chain");

	parked_excl_a: assert property (
		(port_active & port_parked) == '0
	) else $error("parked port in active chain");

	park_gate_a: assert property (
		parked_in_reset_state[NUM_PORTS-1] && port_parked[NUM_PORTS-1]
			&& park_cnt[NUM_PORTS-1] == PARK_CNT_LIMIT |=> !local_port_tck[NUM_PORTS-1]
	) else $error("clock of port parked in reset not stopped");

	unparked_clk_a: assert property (
		!port_parked[0] && s_tck |=> local_port_tck[0]
	) else $error("unparked port clock not running");

	status_set_a: assert property (
		cnt.enabled && cnt.at_zero |=> chain_config[7] ##1 (chain_config[7] || $past(cnt.loaded))
	) else $error("counter status flag not set");
endmodule : msb_bridge_regs

/* design/msb_pkg.sv */
// shared constants and carrier types for the multidrop scan bridge registers
package msb_pkg;
	localparam int IR_WIDTH = 8;
	localparam int BSR_WIDTH = 8;
	localparam int GROUP_WIDTH = 2;
	localparam int MODE_WIDTH = 8;
	localparam int SLOT_WIDTH = 7;
	localparam int ADDR_WIDTH = 6;
	localparam int MAX_PORTS = 5;
	localparam int DEF_PORTS = 3;
	// fixed low bits loaded into the instruction register at capture
	localparam logic [1:0] IR_CAPTURE_LOW = 2'h1;
	// address map of the instruction register while waiting for an address
	localparam logic [5:0] ADDR_INDIV_MAX = 6'h3a;
	localparam logic [5:0] ADDR_BROADCAST = 6'h3b;
	localparam logic [3:0] ADDR_GROUP_PREFIX = 4'hf;
	localparam logic [1:0] ADDR_HIGH_ZERO = 2'h0;
	// group register and mode register reset values
	localparam logic [1:0] GROUP_RESET = 2'h0;
	localparam logic [6:0] MODE_RESET = 7'h01;
	// mode register field positions
	localparam int MODE_PORT_LOW = 0;
	localparam int MODE_CLK_STOP = 3;
	localparam int MODE_LOOPBACK = 4;
	localparam int MODE_PORT_HIGH = 5;
	localparam int MODE_STATUS = 7;
	localparam int LOW_PORTS = 3;
	// backplane clock pulses before a port parked in reset loses its clock
	localparam int PARK_TCK_PULSES = 512;
	localparam int PARK_CNT_WIDTH = 10;
	localparam logic [9:0] PARK_CNT_LIMIT = 10'(PARK_TCK_PULSES);

	// test controller state, one level per state of interest
	typedef struct packed {
		logic tlr;
		logic capture_ir;
		logic shift_ir;
		logic update_ir;
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
	} msb_tap_s;

	// data register selected by the current instruction
	typedef struct packed {
		logic boundary;
		logic bypass;
		logic mode;
		logic group;
	} msb_dr_sel_s;

	// clock counter status from the counter datapath
	typedef struct packed {
		logic enabled;
		logic at_zero;
		logic loaded;
	} msb_cnt_s;

	// selection state of the bridge
	typedef enum logic [1:0] {
		SEL_WAIT = 2'b01,
		SEL_ON = 2'b10
	} msb_sel_e;
endpackage : msb_pkg

/* design/msb_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module msb_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	// the first stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!resetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : msb_sync

/* sim/msb_bridge_regs_tb.sv */
// self-checking bench for the scan bridge registers
`timescale 1ns/1ps
module msb_bridge_regs_tb import msb_pkg::*; ;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic tck_b, tdi_b, tdo_b, tdo_b_oe, selected;
	logic oe_n = 1'b1;
	logic addr_wait = 1'b0;
	logic [SLOT_WIDTH-1:0] slot = 7'h55;
	msb_tap_s tap;
	msb_dr_sel_s dr_sel;
	msb_cnt_s cnt = '0;
	logic [2:0] port_parked = 3'h7;
	logic [2:0] parked_rst = 3'h0;
	logic [2:0] lp_tck, lp_tdi;
	logic [2:0] ring = 3'h0;
	logic [7:0] instruction, chain_config;
	logic [1:0] group_select;
	logic [15:0] dout;
	int rises [3] = '{0, 0, 0};
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	always #2.5 clk = ~clk;

	msb_bridge_regs #(.NUM_PORTS(3)) msb_bridge_regs_inst (
		.clk(clk), .resetn(resetn), .tck_b(tck_b), .tdi_b(tdi_b),
		.tdo_b(tdo_b), .tdo_b_oe(tdo_b_oe), .slot(slot), .oe_n(oe_n), .tap(tap),
		.addr_wait(addr_wait), .dr_sel(dr_sel), .cnt(cnt), .port_parked(port_parked),
		.parked_in_reset_state(parked_rst), .local_port_tck(lp_tck),
		.local_port_tdi(lp_tdi), .local_port_tdo(ring), .selected(selected),
		.instruction(instruction), .chain_config(chain_config), .group_select(group_select)
	);

	// a released backplane output reads as its pull-up level
	msb_master_model msb_master_model_inst (
		.clk(clk), .tdo_b(tdo_b_oe ? tdo_b : 1'b1), .tck_b(tck_b), .tdi_b(tdi_b), .tap(tap),
		.dr_sel(dr_sel)
	);

	// each local ring is one flop on its gated clock, so with its pad a port adds two stages
	for (genvar g = 0; g < 3; g++) begin : ring_gen
		always @(posedge lp_tck[g]) begin
			ring[g] <= lp_tdi[g];
			rises[g] = rises[g] + 1;
		end
	end

	// a hang is cut short well beyond the expected run of about 33000 cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic done(input string name);
		$display("%0t %s finished, %0d checks, %0d errors", $time, name, num_checks, num_errors);
	endtask : done

	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : final_report

	task automatic ir(input logic [7:0] a);
		msb_master_model_inst.scan(1'b1, 4'h0, {a, 8'h00}, dout);
	endtask : ir

	// sel is one-hot {boundary, bypass, mode, group}
	task automatic dr(input logic [3:0] sel, input logic [15:0] d);
		msb_master_model_inst.scan(1'b0, sel, d, dout);
	endtask : dr

	// write the mode register, then time a pattern through bypass and the local chain
	task automatic path(input logic [7:0] mode, input logic [2:0] park, input int lat);
		port_parked <= park;
		dr(4'h2, {mode, 8'h00});
		check(chain_config[6:0], mode[6:0]);
		dr(4'h4, 16'hc5a3);
		check(dout >> lat, 16'hc5a3 & (16'hffff >> lat));
	endtask : path

	task automatic burst(input int n);
		rises = '{0, 0, 0};
		msb_master_model_inst.idle(7'h00, n);
	endtask : burst

	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		check(chain_config, 8'h01);
		check(group_select, 2'h0);
		addr_wait <= 1'b1;
		ir(8'h16);
		check(selected, 1'b0);
		check(dout, 16'hffff);
		ir({2'h0, slot[5:0]});
		check(selected, 1'b1);
		addr_wait <= 1'b0;
		msb_master_model_inst.scan(1'b1, 4'h0, 16'ha55a, dout);
		check(dout[7:0], {slot[5:0], 2'h1});
		check(dout[15:8], 8'h5a);
		check(instruction, 8'ha5);
		addr_wait <= 1'b1;
		ir(8'h3b);
		check(selected, 1'b1);
		done("addressing");
		// each group code is written to one addressed bridge, then the group address goes out
		for (int g = 0; g < 4; g++) begin
			ir({2'h0, slot[5:0]});
			addr_wait <= 1'b0;
			dr(4'h1, {g[1:0], 14'h0});
			check(group_select, g[1:0]);
			addr_wait <= 1'b1;
			ir({6'h0f, g[1:0] ^ 2'h1});
			check(selected, 1'b0);
			ir({6'h0f, g[1:0]});
			check(selected, 1'b1);
		end
		addr_wait <= 1'b0;
		msb_master_model_inst.idle(7'h40, 1);
		check(group_select, 2'h0);
		done("groups");
		addr_wait <= 1'b1;
		ir(8'h3b);
		addr_wait <= 1'b0;
		dr(4'h8, 16'h0000);
		check(dout[7:0], {oe_n, slot});
		done("boundary");
		path(8'h01, 3'h7, 1);
		path(8'h07, 3'h0, 7);
		path(8'h06, 3'h0, 5);
		path(8'h17, 3'h0, 1);
		path(8'h07, 3'h2, 5);
		done("paths");
		// parked port 0 under the stop bit, unparked port 1 beside it
		port_parked <= 3'b101;
		dr(4'h2, 16'h0800);
		burst(20);
		check(rises[0], 0);
		check(rises[1], 20);
		dr(4'h2, 16'h0000);
		burst(20);
		check(rises[0], 20);
		parked_rst <= 3'b100;
		burst(600);
		check(rises[2], 512);
		check(rises[0], 600);
		done("clocks");
		// counter at zero sets the flag and stops the clock of parked port 0; a load clears the flag
		cnt <= 3'b110;
		repeat (3) @(posedge clk);
		check(chain_config[7], 1'b1);
		burst(5);
		check(rises[0], 0);
		cnt <= 3'b001;
		@(posedge clk) cnt <= 3'b000;
		repeat (2) @(posedge clk);
		check(chain_config[7], 1'b0);
		done("counter");
		final_report();
	end
endmodule : msb_bridge_regs_tb

/* sim/msb_master_model.sv */
// backplane test master model: frames tck_b, shifts tdi_b and reads tdo_b
`timescale 1ns/1ps
module msb_master_model import msb_pkg::*; (
	input wire logic clk,
	input wire logic tdo_b,
	output logic tck_b,
	output logic tdi_b,
	output msb_tap_s tap,
	output msb_dr_sel_s dr_sel
);
	// the master keeps its clock low between frames
	initial begin
		tck_b = 1'b0;
		tdi_b = 1'b0;
		tap = '0;
		dr_sel = '0;
	end

	// one 130 ns period as 12 high and 14 low clk cycles, the next tick waiting one more clk edge before its rise;
	// the controller state moves to nxt together with the fall, so the fall already sees nxt
	task automatic tick(input logic [6:0] nxt);
		@(posedge clk) tck_b <= 1'b1;
		repeat (12) @(posedge clk);
		tap <= nxt;
		tck_b <= 1'b0;
		repeat (13) @(posedge clk);
	endtask : tick

	// hold one controller state for n backplane cycles
	task automatic idle(input logic [6:0] t, input int n);
		tap <= t;
		repeat (n) tick(t);
	endtask : idle

	// capture, sixteen shifts lsb first, update; tdo_b is read once each fall has settled
	task automatic scan(input logic ir, input logic [3:0] sel, input logic [15:0] din,
			output logic [15:0] dout);
		dr_sel <= sel;
		tap <= ir ? 7'h20 : 7'h04;
		tick(ir ? 7'h10 : 7'h02);
		for (int i = 0; i < 16; i++) begin
			dout[i] = tdo_b;
			tdi_b <= din[i];
			tick(i == 15 ? (ir ? 7'h08 : 7'h01) : (ir ? 7'h10 : 7'h02));
		end
		tick(7'h00);
	endtask : scan
endmodule : msb_master_model
